// ### hpbw_pkg.sv
// Constants, field layouts and carrier types for the bridge window registers.
// Assumes a single system clock and a byte-offset register port.
package hpbw_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_MEM_LIMIT = 8'h22;
  localparam logic [7:0] OFS_PF_BASE = 8'h24;
  localparam logic [7:0] OFS_PF_LIMIT = 8'h26;
  localparam logic [7:0] OFS_IO_BASE_UP = 8'h30;
  localparam logic [7:0] OFS_IO_LIMIT_UP = 8'h32;
  localparam logic [7:0] OFS_IRQ_LINE = 8'h3c;
  localparam logic [7:0] OFS_BCTL = 8'h3e;

  // Reset values
  localparam logic [15:0] RST_MEM_LIMIT = 16'h0000;
  localparam logic [15:0] RST_PF_BASE = 16'hfff0;
  localparam logic [15:0] RST_PF_LIMIT = 16'h0000;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [7:0] IRQ_LINE_VAL = 8'h00;

  // Window fields: register bits 15:4 carry address bits 31:20
  localparam logic [15:0] WIN_FIELD_MASK = 16'hfff0;
  localparam int WIN_MSB = 15;
  localparam int WIN_LSB = 4;
  localparam int ADDR_WIN_MSB = 31;
  localparam int ADDR_WIN_LSB = 20;
  localparam int NUM_WIN = 2;

  // Bridge control bit positions
  localparam int BCTL_ERR_EN = 11;
  localparam int BCTL_TMO_FLAG = 10;
  localparam int BCTL_SEC_SEL = 9;
  localparam int BCTL_PRI_SEL = 8;

  // Discard timeouts in PCI clocks; the block clock stands for the PCI clock
  localparam int unsigned DT_SLOW_PCLK = 32768;
  localparam int unsigned DT_FAST_PCLK = 1024;
  localparam int unsigned PCLK_PER_CYC = 1;
  localparam int unsigned DT_SLOW_CYC_DEF = DT_SLOW_PCLK / PCLK_PER_CYC;
  localparam int unsigned DT_FAST_CYC = DT_FAST_PCLK / PCLK_PER_CYC;
  localparam int DT_CNT_W = 16;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } hpbw_reg_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } hpbw_pci_cyc_s;

  typedef enum logic [0:0] {
    DT_IDLE = 1'b0,
    DT_RUN = 1'b1
  } hpbw_dt_state_e;

endpackage

// ### hpbw_window_match.sv
// Inclusive range compare of one address window on address bits 31:20.
// Assumes fields already stripped of their reserved low bits.
`timescale 1ns/1ps
`default_nettype none
module hpbw_window_match (
  input wire logic [11:0] i_base,
  input wire logic [11:0] i_limit,
  input wire logic [11:0] i_addr_hi,
  output logic o_hit
);
  import hpbw_pkg::*;

  // Base low bits count as zero, limit low bits as all ones, so a
  // compare on bits 31:20 alone gives 1 MB aligned edges
  always_comb begin
    o_hit = (i_addr_hi >= i_base) && (i_addr_hi <= i_limit);
  end

endmodule
`default_nettype wire

// ### hpbw_discard_timer.sv
// Discard timer for one delayed transaction completion at queue head.
// Assumes head and repeat are single-cycle pulses on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hpbw_discard_timer #(
  parameter int unsigned SLOW_CYC = hpbw_pkg::DT_SLOW_CYC_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_repeat,
  input wire logic i_fast_sel,
  output logic o_discard,
  output logic o_busy
);
  import hpbw_pkg::*;

  hpbw_dt_state_e state;
  logic [DT_CNT_W-1:0] cnt;
  logic [DT_CNT_W-1:0] lim;

  assign lim = i_fast_sel ? DT_CNT_W'(DT_FAST_CYC - 1)
                          : DT_CNT_W'(SLOW_CYC - 1);

  // A new head restarts the count even if one was running
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= DT_IDLE;
      cnt <= '0;
      o_discard <= 1'b0;
    end else begin
      o_discard <= 1'b0;
      case (state)
        DT_IDLE: begin
          if (i_start) begin
            state <= DT_RUN;
            cnt <= '0;
          end
        end
        DT_RUN: begin
          if (i_start) begin
            cnt <= '0;
          end else if (i_repeat) begin
            state <= DT_IDLE;
          end else if (cnt == lim) begin
            state <= DT_IDLE;
            o_discard <= 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        default: state <= DT_IDLE;
      endcase
    end
  end

  assign o_busy = (state == DT_RUN);

  a_start_arms:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_start |=> (state == DT_RUN) && (cnt == '0))
    else $error("Timer not armed by head");

  a_discard_at_lim:
  assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_discard |-> $past(cnt) == $past(lim) && !$past(i_repeat))
    else $error("Discard before timeout");

endmodule
`default_nettype wire

// ### hpbw_top.sv
// What this block does
// - Limit field 15:4 is address 31:20; low address bits count as ones
// - Hub memory goes to PCI; windows only gate PCI target claims
// - Prefetch base field 15:4 is read/write; low four bits reserved
// - Prefetch limit field 15:4 is read/write; low four bits reserved
// - Base decode counts address bits 19:0 as zero
// - Upper I/O base reads zero; writes are ignored
// - Upper I/O limit reads zero; writes are ignored
// - Interrupt routing byte reads as constant zero
// - Discard error enable bit 11 is read/write with no hardware effect
// - Discard timeout flag bit 10 always reads zero
// - Bit 9 selects timeout of 2^15 or 2^10 PCI clocks
// - Discard counter starts when a completion reaches queue head
// - Unrepeated request at timeout is dropped from the queue
// - Primary timeout select bit 8 is read/write, no effect
//
// Top of the bridge window registers and target refusal decode.
// Assumes register port, PCI cycle info and queue pulses on i_sys_clk.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module hpbw_top #(
  parameter int unsigned DT_SLOW_CYC = hpbw_pkg::DT_SLOW_CYC_DEF
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire hpbw_pkg::hpbw_reg_req_s i_reg_req,
  output logic [15:0] o_reg_rdata,
  input wire logic [15:0] i_mem_window_base,
  input wire hpbw_pkg::hpbw_pci_cyc_s i_pci_cyc,
  input wire logic i_dt_head,
  input wire logic i_dt_repeat,
  output logic o_target_refuse,
  output logic o_dt_discard,
  output logic o_dt_busy
);
  import hpbw_pkg::*;

  logic [15:0] mem_window_limit;
  logic [15:0] prefetch_window_base;
  logic [15:0] prefetch_window_limit;
  logic discard_error_enable;
  logic secondary_timeout_select;
  logic primary_timeout_select;
  logic [15:0] bridge_control;
  logic [15:0] next_rdata;
  logic [11:0] win_base [NUM_WIN];
  logic [11:0] win_limit [NUM_WIN];
  logic [NUM_WIN-1:0] win_hit;
  logic wr_limit;
  logic wr_pf_base;
  logic wr_pf_limit;
  logic wr_bctl;
  logic timer_discard;
  logic timer_busy;

  assign wr_limit = i_reg_req.wr && (i_reg_req.addr == OFS_MEM_LIMIT);
  assign wr_pf_base = i_reg_req.wr && (i_reg_req.addr == OFS_PF_BASE);
  assign wr_pf_limit = i_reg_req.wr && (i_reg_req.addr == OFS_PF_LIMIT);
  assign wr_bctl = i_reg_req.wr && (i_reg_req.addr == OFS_BCTL);

  // Limit resets to zero under a base of fff0 elsewhere, so the window is
  // empty until software fills it in
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mem_window_limit <= RST_MEM_LIMIT;
    end else if (wr_limit) begin
      mem_window_limit <= i_reg_req.wdata & WIN_FIELD_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prefetch_window_base <= RST_PF_BASE;
    end else if (wr_pf_base) begin
      prefetch_window_base <= i_reg_req.wdata & WIN_FIELD_MASK;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prefetch_window_limit <= RST_PF_LIMIT;
    end else if (wr_pf_limit) begin
      prefetch_window_limit <= i_reg_req.wdata & WIN_FIELD_MASK;
    end
  end

  // Bits 11, 9 and 8 are the only storage in bridge control
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      discard_error_enable <= 1'b0;
      secondary_timeout_select <= 1'b0;
      primary_timeout_select <= 1'b0;
    end else if (wr_bctl) begin
      discard_error_enable <= i_reg_req.wdata[BCTL_ERR_EN];
      secondary_timeout_select <= i_reg_req.wdata[BCTL_SEC_SEL];
      primary_timeout_select <= i_reg_req.wdata[BCTL_PRI_SEL];
    end
  end

  // Error enable and primary select feed only the read path
  always_comb begin
    bridge_control = RST_ZERO16;
    bridge_control[BCTL_ERR_EN] = discard_error_enable;
    bridge_control[BCTL_TMO_FLAG] = 1'b0;
    bridge_control[BCTL_SEC_SEL] = secondary_timeout_select;
    bridge_control[BCTL_PRI_SEL] = primary_timeout_select;
  end

  // Upper I/O words and the interrupt byte have no storage at all
  always_comb begin
    case (i_reg_req.addr)
      OFS_MEM_LIMIT: next_rdata = mem_window_limit;
      OFS_PF_BASE: next_rdata = prefetch_window_base;
      OFS_PF_LIMIT: next_rdata = prefetch_window_limit;
      OFS_IO_BASE_UP: next_rdata = RST_ZERO16;
      OFS_IO_LIMIT_UP: next_rdata = RST_ZERO16;
      OFS_IRQ_LINE: next_rdata = {8'h00, IRQ_LINE_VAL};
      OFS_BCTL: next_rdata = bridge_control;
      default: next_rdata = RST_ZERO16;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= RST_ZERO16;
    end else if (i_reg_req.rd) begin
      o_reg_rdata <= next_rdata;
    end else begin
      o_reg_rdata <= RST_ZERO16;
    end
  end

  // Window 0 is the non-prefetchable range, window 1 the prefetchable
  assign win_base[0] = i_mem_window_base[WIN_MSB:WIN_LSB];
  assign win_limit[0] = mem_window_limit[WIN_MSB:WIN_LSB];
  assign win_base[1] = prefetch_window_base[WIN_MSB:WIN_LSB];
  assign win_limit[1] = prefetch_window_limit[WIN_MSB:WIN_LSB];

  genvar gi;
  generate
    for (gi = 0; gi < NUM_WIN; gi = gi + 1) begin : g_win
      hpbw_window_match u_match (
        .i_base(win_base[gi]),
        .i_limit(win_limit[gi]),
        .i_addr_hi(i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB]),
        .o_hit(win_hit[gi])
      );
    end
  endgenerate

  // Hub-side cycles never pass here; only PCI target claims are gated
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_target_refuse <= 1'b0;
    end else begin
      o_target_refuse <= i_pci_cyc.valid && (|win_hit);
    end
  end

  hpbw_discard_timer #(
    .SLOW_CYC(DT_SLOW_CYC)
  ) u_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_start(i_dt_head),
    .i_repeat(i_dt_repeat),
    .i_fast_sel(secondary_timeout_select),
    .o_discard(timer_discard),
    .o_busy(timer_busy)
  );

  // Flopped here so both outputs leave the top from a register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dt_discard <= 1'b0;
      o_dt_busy <= 1'b0;
    end else begin
      o_dt_discard <= timer_discard;
      o_dt_busy <= timer_busy;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  a_rdata_idle:
  assert property (!$past(i_reg_req.rd) |-> o_reg_rdata == RST_ZERO16)
    else $error("Read data outside read slot");

  a_limit_write:
  assert property (wr_limit |=>
    mem_window_limit == ($past(i_reg_req.wdata) & WIN_FIELD_MASK))
    else $error("Limit write not stored");

  a_pf_base_write:
  assert property (wr_pf_base |=>
    prefetch_window_base == ($past(i_reg_req.wdata) & WIN_FIELD_MASK))
    else $error("Prefetch base write not stored");

  a_pf_limit_keep:
  assert property (!wr_pf_limit |=> $stable(prefetch_window_limit))
    else $error("Prefetch limit changed without write");

  a_io_upper_zero:
  assert property ($past(i_reg_req.rd) &&
    ($past(i_reg_req.addr) == OFS_IO_BASE_UP ||
     $past(i_reg_req.addr) == OFS_IO_LIMIT_UP) |-> o_reg_rdata == '0)
    else $error("Upper I/O word not zero");

  a_irq_line_zero:
  assert property ($past(i_reg_req.rd) &&
    $past(i_reg_req.addr) == OFS_IRQ_LINE |-> o_reg_rdata == '0)
    else $error("Interrupt routing byte not zero");

  a_bctl_readback:
  assert property (i_reg_req.rd && i_reg_req.addr == OFS_BCTL |=>
    o_reg_rdata == {4'h0, $past(discard_error_enable), 1'b0,
      $past(secondary_timeout_select), $past(primary_timeout_select),
      8'h00})
    else $error("Bridge control readback wrong");

  a_refuse_hit:
  assert property (o_target_refuse |->
    $past(i_pci_cyc.valid) &&
    (($past(i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB]) >=
      $past(win_base[0]) &&
      $past(i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB]) <=
      $past(win_limit[0])) ||
     ($past(i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB]) >=
      $past(win_base[1]) &&
      $past(i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB]) <=
      $past(win_limit[1]))))
    else $error("Refusal without window hit");

  a_fast_discard:
  assert property (secondary_timeout_select && i_dt_head && !i_dt_repeat
    ##1 (!i_dt_head && !i_dt_repeat && secondary_timeout_select) [*8]
    |-> o_dt_busy)
    else $error("Timer stopped early");

  // Bridge control storage follows the write data bit for bit
  a_bctl_write:
  assert property (wr_bctl |=>
    secondary_timeout_select == $past(i_reg_req.wdata[BCTL_SEC_SEL]) &&
    discard_error_enable == $past(i_reg_req.wdata[BCTL_ERR_EN]) &&
    primary_timeout_select == $past(i_reg_req.wdata[BCTL_PRI_SEL]))
    else $error("Bridge control write not stored");

  a_pf_limit_write:
  assert property (wr_pf_limit |=>
    prefetch_window_limit == ($past(i_reg_req.wdata) & WIN_FIELD_MASK))
    else $error("Prefetch limit write not stored");

  // Software owns the window registers; nothing else may move them
  a_limit_keep:
  assert property (!wr_limit |=> $stable(mem_window_limit))
    else $error("Limit changed without write");

  a_pf_base_keep:
  assert property (!wr_pf_base |=> $stable(prefetch_window_base))
    else $error("Prefetch base changed without write");

  // Reserved low nibbles must stay clear whatever software writes
  a_win_low_clear:
  assert property (mem_window_limit[WIN_LSB-1:0] == '0 &&
    prefetch_window_base[WIN_LSB-1:0] == '0 &&
    prefetch_window_limit[WIN_LSB-1:0] == '0)
    else $error("Reserved window bits set");

  a_refuse_valid:
  assert property (!i_pci_cyc.valid |=> !o_target_refuse)
    else $error("Refusal without a valid cycle");

  // Converse of a_refuse_hit: a valid cycle inside either window is refused
  a_refuse_miss:
  assert property (i_pci_cyc.valid &&
    ((i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB] >= win_base[0] &&
      i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB] <= win_limit[0]) ||
     (i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB] >= win_base[1] &&
      i_pci_cyc.addr[ADDR_WIN_MSB:ADDR_WIN_LSB] <= win_limit[1])) |=>
    o_target_refuse)
    else $error("Window hit not refused");

  a_discard_pulse:
  assert property (o_dt_discard |=> !o_dt_discard)
    else $error("Discard pulse longer than one cycle");

  // A repeat in time stops the count, and no drop follows it
  a_repeat_stops:
  assert property (timer_busy && i_dt_repeat && !i_dt_head |=>
    !timer_busy ##1 !o_dt_discard)
    else $error("Repeat did not stop the timer");

  a_head_arms:
  assert property (i_dt_head |=> timer_busy ##1 o_dt_busy)
    else $error("Head did not start the timer");

  a_discard_idle:
  assert property (o_dt_discard |-> !o_dt_busy)
    else $error("Timer still busy at discard");

  c_refuse: cover property (o_target_refuse);
  c_discard: cover property (o_dt_discard);
  c_repeat: cover property (o_dt_busy && i_dt_repeat);
  c_bctl_read: cover property (i_reg_req.rd && i_reg_req.addr == OFS_BCTL);
  c_fast_drop: cover property (o_dt_discard && secondary_timeout_select);

endmodule
`default_nettype wire

// ### hpbw_pci_model.sv
// Behavioural stand-in for PCI initiators and the delayed-transaction queue.
// Assumes bench command pulses on i_sys_clk; outputs change after edges.
`timescale 1ns/1ps
`default_nettype none
module hpbw_pci_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_go_cyc,
  input wire logic [31:0] i_addr,
  input wire logic i_go_head,
  input wire logic i_go_rpt,
  input wire logic [15:0] i_rpt_wait,
  output var hpbw_pkg::hpbw_pci_cyc_s o_pci_cyc,
  output logic o_dt_head,
  output logic o_dt_repeat
);
  import hpbw_pkg::*;
  logic [15:0] rpt_cnt;

  // Idle address flips every cycle so a stale decode cannot pass
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pci_cyc <= '0;
    end else if (i_go_cyc) begin
      o_pci_cyc <= '{valid: 1'b1, addr: i_addr};
    end else begin
      o_pci_cyc <= '{valid: 1'b0, addr: ~o_pci_cyc.addr};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dt_head <= 1'b0;
    end else begin
      o_dt_head <= i_go_head;
    end
  end

  // Initiator repeats after a chosen wait, prompt or slow
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rpt_cnt <= 16'h0000;
      o_dt_repeat <= 1'b0;
    end else begin
      o_dt_repeat <= (rpt_cnt == 16'h0001);
      if (i_go_rpt) begin
        rpt_cnt <= i_rpt_wait;
      end else if (rpt_cnt != 16'h0000) begin
        rpt_cnt <= rpt_cnt - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb_hub_pci_bridge_window_regs.sv
// Self-checking bench for the bridge window registers.
// Assumes the PCI model in its own file and a shortened slow timeout.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_hub_pci_bridge_window_regs;
  import hpbw_pkg::*;
  localparam int unsigned SLOW = 64;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  hpbw_reg_req_s req = '0;
  logic [15:0] mem_base = 16'h0000;
  logic go_cyc = 1'b0;
  logic go_head = 1'b0;
  logic go_rpt = 1'b0;
  logic [31:0] cyc_addr = 32'h0;
  logic [15:0] rpt_wait = 16'h0000;
  hpbw_pci_cyc_s pci;
  logic [15:0] rdata;
  logic head, rpt, refuse, discard, busy;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  logic [7:0] ofs [8] = '{8'h22, 8'h24, 8'h26, 8'h30, 8'h32, 8'h3c, 8'h3e,
    8'h40};
  logic [15:0] rst_v [8] = '{16'h0000, 16'hfff0, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] ones_v [8] = '{16'hfff0, 16'hfff0, 16'hfff0, 16'h0000,
    16'h0000, 16'h0000, 16'h0b00, 16'h0000};
  logic [31:0] adr [7] = '{32'h122fffff, 32'h12300000, 32'h125fffff,
    32'h12600000, 32'h800fffff, 32'h80100000, 32'h7fffffff};
  logic hit [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

  hpbw_top #(.DT_SLOW_CYC(SLOW)) dut_u (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_mem_window_base(mem_base), .i_pci_cyc(pci), .i_dt_head(head),
    .i_dt_repeat(rpt), .o_target_refuse(refuse), .o_dt_discard(discard),
    .o_dt_busy(busy));

  hpbw_pci_model model_u (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_go_cyc(go_cyc), .i_addr(cyc_addr), .i_go_head(go_head),
    .i_go_rpt(go_rpt), .i_rpt_wait(rpt_wait), .o_pci_cyc(pci),
    .o_dt_head(head), .o_dt_repeat(rpt));

  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Expected run is under 2000 cycles
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("Error at %0t: timeout", $time);
      final_report();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    req.wr <= 1'b0;
  endtask

  // Read data stands for exactly one cycle, then returns to zero
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    req.rd <= 1'b0;
    @(negedge i_sys_clk);
    `CHK(rdata, e)
    @(negedge i_sys_clk);
    `CHK(rdata, 16'h0000)
  endtask

  // Refusal shows one cycle after the model presents the cycle
  task automatic probe(input logic [31:0] a, input logic e);
    @(posedge i_sys_clk);
    go_cyc <= 1'b1;
    cyc_addr <= a;
    @(posedge i_sys_clk);
    go_cyc <= 1'b0;
    @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    `CHK(refuse, e)
    @(negedge i_sys_clk);
    `CHK(refuse, 1'b0)
  endtask

  // Counts negedges from the edge after the head command to the drop
  task automatic dt_run(input logic [15:0] ctl, input logic [15:0] w,
    input int lim, input int exp_n);
    wr(OFS_BCTL, ctl);
    rpt_wait <= w;
    @(negedge i_sys_clk);
    `CHK(busy, 1'b0)
    @(posedge i_sys_clk);
    go_head <= 1'b1;
    go_rpt <= (w != 16'h0000);
    @(posedge i_sys_clk);
    go_head <= 1'b0;
    go_rpt <= 1'b0;
    n = 0;
    while (n < lim && discard !== 1'b1) begin
      @(negedge i_sys_clk);
      n++;
      if (n == 5) `CHK(busy, 1'b1)
    end
    `CHK(n, exp_n)
    `CHK(busy, 1'b0)
    $display("test discard timer ctl %h wait %0d done", ctl, w);
  endtask

  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], rst_v[i]);
    end
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      wr(ofs[i], 16'hffff);
    end
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], ones_v[i]);
    end
    wr(OFS_BCTL, 16'h0000);
    rd(OFS_BCTL, 16'h0000);
    $display("test register access done");
    wr(OFS_MEM_LIMIT, 16'h125f);
    mem_base <= 16'h1230;
    wr(OFS_PF_BASE, 16'h800a);
    wr(OFS_PF_LIMIT, 16'h8000);
    for (int j = 0; j < 7; j++) begin
      probe(adr[j], hit[j]);
    end
    $display("test window decode done");
    dt_run(16'h0b00, 16'h0000, 1100, 1027);
    dt_run(16'h0000, 16'h0000, 200, SLOW + 3);
    dt_run(16'h0000, 16'h000a, 200, 200);
    final_report();
  end
endmodule
`default_nettype wire
